// ---- design/monitor_regs.sv ----
// Control and status register bank of the regulator's high-temperature
// sensor and low-voltage detector, reached over Avalon-MM with waitrequest.
// Assumes comparator levels are asynchronous and the mode inputs are
// synchronous to clk.
//
// Overview of operation
// - Control bits 7 and 6 are test bits writable only in special mode.
// - Bit 5 routes bandgap when one, temperature voltage when zero, only with bit 4 set.
// - Bit 4 connects the selected voltage to the converter, else the external input.
// - Bit 3 enables the temperature sensing function.
// - Bit 2 is read-only hot status, one only when hot in full performance mode.
// - Bit 1 makes a set temperature flag request an interrupt.
// - The temperature flag sets on any status change and clears only on a written one.
// - Entering reduced power mode does not clear the temperature flag.
// - Low-voltage bit 2 is read-only status, one only when undervolt in full performance.
// - Low-voltage bit 1 makes a set low-voltage flag request an interrupt.
// - The low-voltage flag sets on any status change and clears only on a written one.
// - Entering reduced power mode does not clear the low-voltage flag.
// - Low-voltage bits 7 to 3 read zero and ignore writes.
`timescale 1ns/100ps
module monitor_regs
  import monitor_regs_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Analog comparators and regulator mode
  input wire logic hot_detect_raw,
  input wire logic undervolt_raw,
  input wire logic full_performance_mode,
  input wire logic special_mode,
  // Analog controls
  output logic temp_sense_enable,
  output logic [1:0] sensor_test_bits,
  output logic adc_internal_sel,
  output logic adc_bandgap_sel,
  output logic adc_temp_sel,
  // Interrupts
  output logic hot_irq_req,
  output logic undervolt_irq_req,
  output logic irq
);

  if (ADDR_W < 12)
  begin : g_addr_check
    $error("ADDR_W must be at least 12 to reach the register map");
  end

  logic [1:0] test_q;
  logic src_sel_q;
  logic access_en_q;
  logic sense_en_q;
  logic hot_ie_q;
  logic hot_flag_q;
  logic hot_status_q;
  logic uv_ie_q;
  logic uv_flag_q;
  logic uv_status_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] rd_stat_q;
  logic [1:0] cmp_sync;
  logic hot_status_d;
  logic uv_status_d;
  logic hot_event;
  logic uv_event;
  logic acc_wr;
  logic acc_rd;
  logic lane0;
  logic [7:0] wbyte;
  logic wr_temp;
  logic wr_lv;
  logic wr_mask;
  logic rd_stat;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] r);
    hit = (a == ADDR_W'(r));
  endfunction

  function automatic logic [7:0] ctl_byte(input logic [1:0] t, input logic v,
                                          input logic a, input logic e, input logic s,
                                          input logic ie, input logic f);
    ctl_byte = {t, v, a, e, s, ie, f};
  endfunction

  // Bus handshake: a request is answered with waitrequest low one cycle
  // after it rises, and takes effect at the edge that samples it low.
  assign acc_wr = write && !waitrequest;
  assign acc_rd = read && !waitrequest;
  assign lane0 = byteenable[0];
  assign wbyte = writedata[7:0];
  assign wr_temp = acc_wr && lane0 && hit(address, TEMP_CTL_ADDR);
  assign wr_lv = acc_wr && lane0 && hit(address, LV_CTL_ADDR);
  assign wr_mask = acc_wr && lane0 && hit(address, IRQ_MASK_ADDR);
  assign rd_stat = acc_rd && hit(address, IRQ_STAT_ADDR);

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      waitrequest <= 1'b1;
    end
    else
    begin
      waitrequest <= !((read || write) && waitrequest);
    end
  end

  // Read data are captured when waitrequest drops and stand while it is low.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      readdata <= UNMAPPED_READ;
      rd_stat_q <= '0;
    end
    else if (read && waitrequest)
    begin
      rd_stat_q <= '0;
      if (hit(address, TEMP_CTL_ADDR))
      begin
        readdata <= {24'h000000, ctl_byte(test_q, src_sel_q, access_en_q, sense_en_q,
                                          hot_status_q, hot_ie_q, hot_flag_q)};
      end
      else if (hit(address, LV_CTL_ADDR))
      begin
        readdata <= {24'h000000, ctl_byte(2'h0, 1'b0, 1'b0, 1'b0,
                                          uv_status_q, uv_ie_q, uv_flag_q)};
      end
      else if (hit(address, IRQ_STAT_ADDR))
      begin
        readdata <= {30'h0000_0000, irq_stat_q};
        rd_stat_q <= irq_stat_q;
      end
      else if (hit(address, IRQ_MASK_ADDR))
      begin
        readdata <= {30'h0000_0000, irq_mask_q};
      end
      else
      begin
        readdata <= UNMAPPED_READ;
      end
    end
  end

  level_sync #(
    .WIDTH(2)
  ) u_cmp_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in({undervolt_raw, hot_detect_raw}),
    .sync_out(cmp_sync)
  );

  assign hot_status_d = cmp_sync[0] && full_performance_mode && sense_en_q;
  assign uv_status_d = cmp_sync[1] && full_performance_mode;
  assign hot_event = hot_status_d != hot_status_q;
  assign uv_event = uv_status_d != uv_status_q;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      hot_status_q <= 1'b0;
      uv_status_q <= 1'b0;
    end
    else
    begin
      hot_status_q <= hot_status_d;
      uv_status_q <= uv_status_d;
    end
  end

  // Temperature control register; status and flag bits are not stored here.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      test_q <= TEMP_CTL_RST[TEST_HI_BIT:TEST_LO_BIT];
      src_sel_q <= TEMP_CTL_RST[SRC_SEL_BIT];
      access_en_q <= TEMP_CTL_RST[ACCESS_EN_BIT];
      sense_en_q <= TEMP_CTL_RST[SENSE_EN_BIT];
      hot_ie_q <= TEMP_CTL_RST[IE_BIT];
    end
    else if (wr_temp)
    begin
      if (special_mode)
      begin
        test_q <= wbyte[TEST_HI_BIT:TEST_LO_BIT];
      end
      src_sel_q <= wbyte[SRC_SEL_BIT];
      access_en_q <= wbyte[ACCESS_EN_BIT];
      sense_en_q <= wbyte[SENSE_EN_BIT];
      hot_ie_q <= wbyte[IE_BIT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      uv_ie_q <= LV_CTL_RST[IE_BIT];
    end
    else if (wr_lv)
    begin
      uv_ie_q <= wbyte[IE_BIT];
    end
  end

  // Flags ignore the regulator mode, so a move to reduced power keeps them.
  // temperature flag set and clear
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      hot_flag_q <= TEMP_CTL_RST[FLAG_BIT];
    end
    else
    begin
      hot_flag_q <= (hot_flag_q && !(wr_temp && wbyte[FLAG_BIT])) || hot_event;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      uv_flag_q <= LV_CTL_RST[FLAG_BIT];
    end
    else
    begin
      uv_flag_q <= (uv_flag_q && !(wr_lv && wbyte[FLAG_BIT])) || uv_event;
    end
  end

  // Only bits that were returned by the read are cleared, so an event
  // landing between capture and acceptance is not lost.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      irq_stat_q <= '0;
      irq_mask_q <= IRQ_MASK_RST;
    end
    else
    begin
      irq_stat_q <= (irq_stat_q & ~(rd_stat ? rd_stat_q : '0)) | {uv_event, hot_event};
      if (wr_mask)
      begin
        irq_mask_q <= wbyte[IRQ_W-1:0];
      end
    end
  end

  // Analog controls and interrupt requests, all from flip-flops.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      temp_sense_enable <= 1'b0;
      sensor_test_bits <= 2'h0;
      adc_internal_sel <= 1'b0;
      adc_bandgap_sel <= 1'b0;
      adc_temp_sel <= 1'b0;
    end
    else
    begin
      temp_sense_enable <= sense_en_q;
      sensor_test_bits <= test_q;
      adc_internal_sel <= access_en_q;
      adc_bandgap_sel <= access_en_q && src_sel_q;
      adc_temp_sel <= access_en_q && !src_sel_q;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      hot_irq_req <= 1'b0;
      undervolt_irq_req <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      hot_irq_req <= hot_flag_q && hot_ie_q;
      undervolt_irq_req <= uv_flag_q && uv_ie_q;
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence seq_temp_write;
    wr_temp;
  endsequence

  sequence seq_hot_change;
    $changed(hot_status_q);
  endsequence

  sequence seq_uv_change;
    $changed(uv_status_q);
  endsequence

  AST_TEST_BITS_LOCKED: assert property (seq_temp_write and !special_mode
    |=> $stable(test_q))
    else $error("Test bits changed outside special mode.");
  AST_ROUTE_SELECT: assert property (##1
    adc_bandgap_sel == $past(access_en_q && src_sel_q)
    && adc_temp_sel == $past(access_en_q && !src_sel_q))
    else $error("Converter source does not follow select and enable.");
  AST_ROUTE_EXTERNAL: assert property (!access_en_q |=> !adc_internal_sel
    && !adc_bandgap_sel && !adc_temp_sel)
    else $error("Internal voltage routed while access is off.");
  AST_SENSE_ENABLE: assert property (seq_temp_write |=> ##1
    temp_sense_enable == $past(wbyte[SENSE_EN_BIT], 2))
    else $error("Sensor enable does not follow the written bit.");
  AST_HOT_STATUS_MODE: assert property (!full_performance_mode |=> !hot_status_q)
    else $error("Hot status set outside full performance mode.");
  AST_HOT_REQUEST: assert property (hot_flag_q && hot_ie_q |=> hot_irq_req)
    else $error("Temperature interrupt not requested.");
  AST_HOT_NO_REQUEST: assert property (!hot_ie_q |=> !hot_irq_req)
    else $error("Temperature interrupt requested while disabled.");
  AST_HOT_FLAG_SET: assert property (seq_hot_change |-> hot_flag_q)
    else $error("Temperature flag missed a status change.");
  AST_HOT_FLAG_ZERO_WRITE: assert property (seq_temp_write and
    hot_flag_q && !wbyte[FLAG_BIT] |=> hot_flag_q)
    else $error("Writing zero cleared the temperature flag.");
  AST_HOT_FLAG_LOW_POWER: assert property ($fell(full_performance_mode)
    && hot_flag_q && !wr_temp |=> hot_flag_q)
    else $error("Temperature flag lost on mode change.");
  AST_UV_STATUS_MODE: assert property (!full_performance_mode |=> !uv_status_q)
    else $error("Low-voltage status set outside full performance mode.");
  AST_UV_REQUEST: assert property (undervolt_irq_req == $past(uv_flag_q && uv_ie_q)
    or $past(!reset_n))
    else $error("Low-voltage request does not follow flag and enable.");
  AST_UV_FLAG_SET: assert property (seq_uv_change |-> uv_flag_q)
    else $error("Low-voltage flag missed a status change.");
  AST_UV_FLAG_LOW_POWER: assert property ($fell(full_performance_mode)
    && uv_flag_q && !wr_lv |=> uv_flag_q)
    else $error("Low-voltage flag lost on mode change.");
  AST_LV_UNUSED_ZERO: assert property (read && waitrequest && hit(address, LV_CTL_ADDR)
    |=> readdata[7:3] == 5'h00)
    else $error("Unimplemented low-voltage bits read nonzero.");
  AST_SET_BEATS_CLEAR: assert property (hot_event && wr_temp && wbyte[FLAG_BIT]
    |=> hot_flag_q)
    else $error("Clearing write swallowed a new temperature event.");
  AST_BUS_ANSWER: assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("Bus answer not given one cycle after the request.");

endmodule

// ---- pkg/monitor_regs_pkg.sv ----
// Register map, field positions and reset values of the temperature and
// low-voltage monitor register bank. Shared by the bank and its testbench.
package monitor_regs_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [9:0] TEMP_CTL_IDX = 10'h2F0;
  localparam logic [9:0] LV_CTL_IDX = 10'h2F1;
  localparam logic [9:0] IRQ_STAT_IDX = 10'h300;
  localparam logic [9:0] IRQ_MASK_IDX = 10'h301;

  // Byte addresses.
  localparam logic [11:0] TEMP_CTL_ADDR = {TEMP_CTL_IDX, 2'b00};
  localparam logic [11:0] LV_CTL_ADDR = {LV_CTL_IDX, 2'b00};
  localparam logic [11:0] IRQ_STAT_ADDR = {IRQ_STAT_IDX, 2'b00};
  localparam logic [11:0] IRQ_MASK_ADDR = {IRQ_MASK_IDX, 2'b00};

  // Temperature control fields.
  localparam int TEST_HI_BIT = 7;
  localparam int TEST_LO_BIT = 6;
  localparam int SRC_SEL_BIT = 5;
  localparam int ACCESS_EN_BIT = 4;
  localparam int SENSE_EN_BIT = 3;
  localparam int STATUS_BIT = 2;
  localparam int IE_BIT = 1;
  localparam int FLAG_BIT = 0;

  // Interrupt status and mask layout.
  localparam int IRQ_HOT_BIT = 0;
  localparam int IRQ_UV_BIT = 1;
  localparam int IRQ_W = 2;

  // Reset values.
  localparam logic [7:0] TEMP_CTL_RST = 8'h00;
  localparam logic [7:0] LV_CTL_RST = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

endpackage

// ---- design/level_sync.sv ----
// Two-stage synchroniser for a group of independent level signals.
// Assumes each bit is a slow level; bits are not coherent with each other.
`timescale 1ns/100ps
module level_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      meta_q <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// ---- verif/monitor_regs_tb.sv ----
// Self-checking testbench of the temperature and low-voltage monitor bank.
// Assumes the bank answers every Avalon request within a bounded wait and
// that comparator changes reach the status bits within a few clocks.
`timescale 1ns/100ps
`define CHK(g, e) \
  begin \
    check_count++; \
    if ((g) !== (e)) \
    begin \
      failures++; \
      $display("[ERR] %0t got %h expected %h", $time, (g), (e)); \
    end \
  end
module monitor_regs_tb
  import monitor_regs_pkg::*;
;
  logic clk, reset_n, read, write, waitrequest, special_mode, perf_mode;
  logic [11:0] address;
  logic [3:0] byteenable;
  logic [31:0] writedata, readdata, rd;
  logic [1:0] raw, sensor_test_bits;
  logic temp_sense_enable, adc_internal_sel, adc_bandgap_sel, adc_temp_sel;
  logic hot_irq_req, undervolt_irq_req, irq;
  logic [7:0] v;
  logic [3:0] route;
  logic [7:0] cfg [4] = '{8'h38, 8'h18, 8'h20, 8'h0C};
  int failures, check_count;

  monitor_regs u_dut (
    .clk(clk),
    .reset_n(reset_n),
    .address(address),
    .read(read),
    .write(write),
    .byteenable(byteenable),
    .writedata(writedata),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .hot_detect_raw(raw[0]),
    .undervolt_raw(raw[1]),
    .full_performance_mode(perf_mode),
    .special_mode(special_mode),
    .temp_sense_enable(temp_sense_enable),
    .sensor_test_bits(sensor_test_bits),
    .adc_internal_sel(adc_internal_sel),
    .adc_bandgap_sel(adc_bandgap_sel),
    .adc_temp_sel(adc_temp_sel),
    .hot_irq_req(hot_irq_req),
    .undervolt_irq_req(undervolt_irq_req),
    .irq(irq)
  );

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task end_sim();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One Avalon transfer: the request rises just after a rising edge and
  // stands until the rising edge that samples waitrequest low.
  task bus(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= {24'h000000, d};
    byteenable <= be;
    @(posedge clk);
    while (waitrequest !== 1'b0 && n < 20)
    begin
      n++;
      @(posedge clk);
    end
    if (waitrequest !== 1'b0)
    begin
      failures++;
      $display("[ERR] %0t bus timeout", $time);
      end_sim();
    end
    else
    begin
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
    end
  endtask

  task wr(input logic [11:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask

  task rchk(input logic [11:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 4'hF);
    `CHK(rd, {24'h000000, e})
  endtask

  // Two sync flops, the status flop and the request flop, plus margin.
  task settle();
    repeat (6) @(posedge clk);
  endtask

  function logic req(input int ch);
    return ch ? undervolt_irq_req : hot_irq_req;
  endfunction

  task chan(input int ch);
    logic [11:0] a;
    logic [7:0] en;
    a = ch ? LV_CTL_ADDR : TEMP_CTL_ADDR;
    en = ch ? 8'h00 : 8'h08;
    wr(a, en | 8'h02);
    raw[ch] <= 1'b1;
    settle();
    rchk(a, en | 8'h07);
    `CHK(req(ch), 1'b1)
    `CHK(irq, 1'b0)
    wr(a, en | 8'h02);
    rchk(a, en | 8'h07);
    wr(a, en | 8'h03);
    settle();
    rchk(a, en | 8'h06);
    `CHK(req(ch), 1'b0)
    wr(a, en);
    raw[ch] <= 1'b0;
    settle();
    rchk(a, en | 8'h01);
    `CHK(req(ch), 1'b0)
    perf_mode <= 1'b0;
    settle();
    rchk(a, en | 8'h01);
    raw[ch] <= 1'b1;
    settle();
    rchk(a, en | 8'h01);
    raw[ch] <= 1'b0;
    settle();
    perf_mode <= 1'b1;
    settle();
    wr(a, en | 8'h01);
    rchk(a, en);
    // Raised here, the change reaches the status bit three edges on, which
    // is the edge that accepts the clearing write below.
    raw[ch] <= 1'b1;
    wr(a, en | 8'h01);
    settle();
    rchk(a, en | 8'h05);
    raw[ch] <= 1'b0;
    settle();
    wr(a, en | 8'h01);
    rchk(a, en);
  endtask

  initial
  begin
    reset_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 12'h000;
    byteenable = 4'hF;
    writedata = 32'h0000_0000;
    raw = 2'b00;
    perf_mode = 1'b1;
    special_mode = 1'b0;
    failures = 0;
    check_count = 0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    rchk(TEMP_CTL_ADDR, TEMP_CTL_RST);
    rchk(LV_CTL_ADDR, LV_CTL_RST);
    rchk(IRQ_MASK_ADDR, 8'(IRQ_MASK_RST));
    rchk(12'h010, UNMAPPED_READ[7:0]);
    wr(TEMP_CTL_ADDR, 8'hC0);
    rchk(TEMP_CTL_ADDR, 8'h00);
    `CHK(sensor_test_bits, 2'b00)
    special_mode <= 1'b1;
    wr(TEMP_CTL_ADDR, 8'hC0);
    rchk(TEMP_CTL_ADDR, 8'hC0);
    `CHK(sensor_test_bits, 2'b11)
    wr(TEMP_CTL_ADDR, 8'h00);
    special_mode <= 1'b0;
    rchk(TEMP_CTL_ADDR, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      v = cfg[i];
      wr(TEMP_CTL_ADDR, v);
      rchk(TEMP_CTL_ADDR, v & 8'h3B);
      @(posedge clk);
      route = {adc_internal_sel, adc_bandgap_sel, adc_temp_sel, temp_sense_enable};
      `CHK(route, {v[4], v[4] & v[5], v[4] & ~v[5], v[3]})
    end
    chan(0);
    chan(1);
    wr(LV_CTL_ADDR, 8'hFA);
    rchk(LV_CTL_ADDR, 8'h02);
    wr(LV_CTL_ADDR, 8'h00);
    rchk(IRQ_STAT_ADDR, 8'((1 << IRQ_HOT_BIT) | (1 << IRQ_UV_BIT)));
    rchk(IRQ_STAT_ADDR, 8'h00);
    bus(1'b1, IRQ_MASK_ADDR, 8'h03, 4'hE);
    rchk(IRQ_MASK_ADDR, 8'h00);
    wr(IRQ_MASK_ADDR, 8'h03);
    rchk(IRQ_MASK_ADDR, 8'h03);
    raw[1] <= 1'b1;
    settle();
    `CHK(irq, 1'b1)
    rchk(IRQ_STAT_ADDR, 8'(1 << IRQ_UV_BIT));
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    wr(IRQ_MASK_ADDR, 8'h01);
    raw[1] <= 1'b0;
    settle();
    `CHK(irq, 1'b0)
    rchk(IRQ_STAT_ADDR, 8'(1 << IRQ_UV_BIT));
    wr(LV_CTL_ADDR, 8'h01);
    rchk(LV_CTL_ADDR, 8'h00);
    end_sim();
  end
endmodule
